//--- shared/clk_start_pkg.sv
// Constants for the clock start-up and data timeout block.
// Assumes a 32-bit Avalon-MM register port, word addressed by byte offset.
package clk_start_pkg;
	// Byte addresses of the registers
	localparam logic [7:0] clock_ctrl_addr   = 8'h2C;
	localparam logic [7:0] timeout_set_addr  = 8'h2E;
	localparam logic [7:0] irq_status_addr   = 8'h30;
	localparam logic [7:0] irq_enable_addr   = 8'h34;
	localparam logic [7:0] irq_clear_addr    = 8'h38;
	localparam logic [7:0] link_ctrl_addr    = 8'h3C;
	// Index of the timeout register, two bytes into its word
	localparam int         timeout_lane_lsb  = 16;
	// Clock control fields
	localparam int         osc_run_bit       = 0;
	localparam int         settled_bit       = 1;
	localparam int         card_clock_bit    = 2;
	localparam int         synth_enable_bit  = 3;
	// Own control word fields
	localparam int         wait_start_bit    = 0;
	localparam int         wait_stop_bit     = 1;
	// Interrupt status fields
	localparam int         irq_settled_bit   = 0;
	localparam int         irq_timeout_bit   = 1;
	localparam int         irq_width         = 2;
	// Timeout code
	localparam int         code_width        = 4;
	localparam logic [3:0] code_reserved     = 4'hF;
	localparam logic [3:0] code_reset        = 4'h0;
	localparam int         timeout_exp_base  = 13;
	// Oscillator and synthesizer settling
	localparam int         osc_settle_ns     = 1000;
	localparam int         synth_lock_ns     = 5000;
	localparam int         clk_period_ns     = 10;
	localparam int         osc_settle_cyc    = (osc_settle_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int         synth_lock_cyc    = (synth_lock_ns + clk_period_ns - 1) / clk_period_ns;
	// Base clock divider ratio, core cycles per base tick
	localparam int         base_div_default  = 100;
	localparam logic [31:0] bus_unmapped     = 32'h0000_0000;
	typedef enum logic [1:0] {
		clk_off    = 2'b00,
		clk_settle = 2'b01,
		clk_run    = 2'b10,
		clk_lock   = 2'b11
	} clk_state_t;
endpackage

//--- shared/timeout_if.sv
// Carries the timeout request and result between core and counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface timeout_if;
	logic       start;
	logic       stop;
	logic [3:0] code;
	logic       base_tick;
	logic       expired;
	modport core (output start, output stop, output code, output base_tick, input expired);
	modport counter (input start, input stop, input code, input base_tick, output expired);
endinterface

//--- src/data_timeout_counter.sv
// Data-line timeout counter driven by base clock ticks.
// Assumes ticks come as one-cycle pulses on the core clock.
`timescale 1ns/1ps
module data_timeout_counter (
	input  wire logic clk,
	input  wire logic rstn,
	timeout_if.counter tif
);
	logic [27:0] count;
	logic        active;
	logic [27:0] limit;

	always_comb begin
		limit = 28'h0;
		if (tif.code != clk_start_pkg::code_reserved) begin
			limit = 28'h1 << (5'(clk_start_pkg::timeout_exp_base) + 5'(tif.code));
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count <= 28'h0;
			active <= 1'b0;
			tif.expired <= 1'b0;
		end else begin
			tif.expired <= 1'b0;
			if (tif.start) begin
				count <= 28'h0;
				active <= 1'b1;
			end else if (tif.stop) begin
				active <= 1'b0;
			end else if (active && tif.base_tick && limit != 28'h0) begin
				if (count == limit - 28'h1) begin
					tif.expired <= 1'b1;
					active <= 1'b0;
				end else begin
					count <= count + 28'h1;
				end
			end
		end
	end
endmodule // data_timeout_counter

//--- src/clock_start_ctrl.sv
// Clock start-up control, synthesizer lock tracking and data timeout setting.
// Assumes an Avalon-MM master on clk and a card detect pin from outside.
//
// Function
// - Settled set after oscillator stabilises, no synthesizer
// - Synthesizer enable rise clears settled until lock
// - Synthesizer locks only from running oscillator
// - Run bit low halts internal clock
// - Registers stay accessible while clock halted
// - Run bit starts and stops oscillator
// - Card detection ignores run bit
// - Timeout code sets data-line timeout interval
// - Interval is base period times 2^(13+code)
// - Timeout register bits 7-4 reserved
// - Card clock gate stops or resumes clock
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module clock_start_ctrl #(
	parameter int base_div   = clk_start_pkg::base_div_default,
	parameter int settle_cyc = clk_start_pkg::osc_settle_cyc,
	parameter int lock_cyc   = clk_start_pkg::synth_lock_cyc
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        card_detect_pin,
	output logic             card_present,
	output logic             internal_clk_en,
	output logic             card_side_clk_en,
	output logic             data_timeout,
	output logic             irq
);
	// Counters are 16 bits wide; larger counts would wrap silently
	if (base_div < 1 || base_div > 65536 || settle_cyc < 1 || lock_cyc < 1
			|| settle_cyc > 65535 || lock_cyc > 65535) begin : g_bad_params
		$error("clock_start_ctrl: counts out of range");
	end

	timeout_if tif ();
	data_timeout_counter u_counter (
		.clk  (clk),
		.rstn (rstn),
		.tif  (tif)
	);

	logic                   osc_run;
	logic                   synth_en;
	logic                   card_clock_gate;
	logic                   settled;
	logic [3:0]             timeout_code;
	logic [1:0]             irq_status;
	logic [1:0]             irq_enable;
	logic [15:0]            wait_cnt;
	logic [15:0]            base_cnt;
	logic                   detect_meta;
	logic                   detect_sync;
	logic                   settled_prev;
	logic                   start_pulse;
	logic                   stop_pulse;
	logic                   ack;
	clk_start_pkg::clk_state_t state;
	clk_start_pkg::clk_state_t next_state;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
		return addr[7:2] == reg_addr[7:2];
	endfunction

	// One wait state per access keeps read data from a flip-flop
	wire req = (avs_read || avs_write) && !ack;
	wire wr  = avs_write && ack;

	// Wait request straight from a flop, high through reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !req;
		end
	end

	always_comb begin
		ack = !avs_waitrequest;
	end

	// Control writes; the register file runs on clk, not the gated clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			osc_run <= 1'b0;
			synth_en <= 1'b0;
			card_clock_gate <= 1'b0;
			timeout_code <= clk_start_pkg::code_reset;
			irq_enable <= 2'b00;
			start_pulse <= 1'b0;
			stop_pulse <= 1'b0;
		end else begin
			start_pulse <= 1'b0;
			stop_pulse <= 1'b0;
			if (wr && hit(avs_address, clk_start_pkg::clock_ctrl_addr) && avs_byteenable[0]) begin
				osc_run <= avs_writedata[clk_start_pkg::osc_run_bit];
				card_clock_gate <= avs_writedata[clk_start_pkg::card_clock_bit];
				synth_en <= avs_writedata[clk_start_pkg::synth_enable_bit];
			end
			if (wr && hit(avs_address, clk_start_pkg::timeout_set_addr) && avs_byteenable[2]) begin
				// Upper nibble is dropped, it holds nothing
				timeout_code <= avs_writedata[clk_start_pkg::timeout_lane_lsb +: 4];
			end
			if (wr && hit(avs_address, clk_start_pkg::irq_enable_addr) && avs_byteenable[0]) begin
				irq_enable <= avs_writedata[1:0];
			end
			if (wr && hit(avs_address, clk_start_pkg::link_ctrl_addr) && avs_byteenable[0]) begin
				start_pulse <= avs_writedata[clk_start_pkg::wait_start_bit];
				stop_pulse <= avs_writedata[clk_start_pkg::wait_stop_bit];
			end
		end
	end

	// Oscillator and synthesizer sequencing
	always_comb begin
		next_state = state;
		unique case (state)
			clk_start_pkg::clk_off: begin
				if (osc_run) next_state = clk_start_pkg::clk_settle;
			end
			clk_start_pkg::clk_settle: begin
				if (!osc_run) next_state = clk_start_pkg::clk_off;
				else if (wait_cnt == 16'(settle_cyc - 1)) next_state = clk_start_pkg::clk_run;
			end
			clk_start_pkg::clk_run: begin
				if (!osc_run) next_state = clk_start_pkg::clk_off;
				else if (synth_en) next_state = clk_start_pkg::clk_lock;
			end
			clk_start_pkg::clk_lock: begin
				if (!osc_run) next_state = clk_start_pkg::clk_off;
				else if (!synth_en) next_state = clk_start_pkg::clk_run;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= clk_start_pkg::clk_off;
			wait_cnt <= 16'h0;
		end else begin
			state <= next_state;
			if (next_state != state) begin
				wait_cnt <= 16'h0;
			end else if (wait_cnt != 16'hFFFF) begin
				wait_cnt <= wait_cnt + 16'h1;
			end
		end
	end

	// Settled flag; enable rise drops it once until lock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			settled <= 1'b0;
		end else begin
			unique case (state)
				clk_start_pkg::clk_off: settled <= 1'b0;
				clk_start_pkg::clk_settle: settled <= 1'b0;
				clk_start_pkg::clk_run: begin
					if (synth_en) settled <= 1'b0;
					else settled <= 1'b1;
				end
				clk_start_pkg::clk_lock: begin
					if (wait_cnt >= 16'(lock_cyc - 1)) settled <= 1'b1;
				end
			endcase
		end
	end

	// Internal clock halts with run bit low
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			internal_clk_en <= 1'b0;
			card_side_clk_en <= 1'b0;
		end else begin
			internal_clk_en <= osc_run;
			// Hardware relies on software waiting for settled first
			card_side_clk_en <= card_clock_gate && osc_run;
		end
	end

	// Card detect runs on clk, independent of the run bit
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			detect_meta <= 1'b0;
			detect_sync <= 1'b0;
			card_present <= 1'b0;
		end else begin
			detect_meta <= card_detect_pin;
			detect_sync <= detect_meta;
			card_present <= detect_sync;
		end
	end

	// Base clock divider for the timeout counter
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			base_cnt <= 16'h0;
		end else if (base_cnt == 16'(base_div - 1)) begin
			base_cnt <= 16'h0;
		end else begin
			base_cnt <= base_cnt + 16'h1;
		end
	end

	always_comb begin
		tif.start = start_pulse;
		tif.stop = stop_pulse;
		tif.code = timeout_code;
		tif.base_tick = (base_cnt == 16'(base_div - 1));
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			data_timeout <= 1'b0;
		end else begin
			data_timeout <= tif.expired;
		end
	end

	// Sticky events; a set in the clear cycle wins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			settled_prev <= 1'b0;
			irq_status <= 2'b00;
		end else begin
			settled_prev <= settled;
			for (int i = 0; i < clk_start_pkg::irq_width; i++) begin
				if (wr && hit(avs_address, clk_start_pkg::irq_clear_addr)
						&& avs_byteenable[0] && avs_writedata[i]) begin
					irq_status[i] <= 1'b0;
				end
			end
			if (settled && !settled_prev) irq_status[clk_start_pkg::irq_settled_bit] <= 1'b1;
			if (tif.expired) irq_status[clk_start_pkg::irq_timeout_bit] <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_enable);
		end
	end

	// Read data registered at the access edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && req) begin
			avs_readdata <= clk_start_pkg::bus_unmapped;
			if (hit(avs_address, clk_start_pkg::clock_ctrl_addr)) begin
				// Timeout code shares this word; its upper nibble reads zero
				avs_readdata <= {12'h0, timeout_code, 12'h0, synth_en, card_clock_gate,
					settled, osc_run};
			end else if (hit(avs_address, clk_start_pkg::irq_status_addr)) begin
				avs_readdata <= {30'h0, irq_status};
			end else if (hit(avs_address, clk_start_pkg::irq_enable_addr)) begin
				avs_readdata <= {30'h0, irq_enable};
			end else if (hit(avs_address, clk_start_pkg::link_ctrl_addr)) begin
				avs_readdata <= {31'h0, card_present};
			end
		end
	end
endmodule // clock_start_ctrl

//--- sim/clock_start_ctrl_assertions.sv
// Port-level checks for the clock start-up and timeout block.
// Assumes it is bound onto clock_start_ctrl, one clock, reset low.
`timescale 1ns/1ps
module clock_start_ctrl_assertions (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        card_detect_pin,
	input wire logic        card_present,
	input wire logic        internal_clk_en,
	input wire logic        card_side_clk_en,
	input wire logic        data_timeout
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence run_wr(logic v);
		avs_write && !avs_waitrequest && avs_byteenable[0] &&
		avs_address == clk_start_pkg::clock_ctrl_addr && avs_writedata[0] == v;
	endsequence
	chk_run_start: assert property (run_wr(1'b1) |-> ##[1:2] internal_clk_en)
		else $error("oscillator not started");
	chk_run_halt: assert property (run_wr(1'b0) |-> ##[1:2] !internal_clk_en)
		else $error("oscillator not halted");
	chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("access not answered");
	chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait release too long");
	chk_data_hold: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved");
	chk_gate_needs_run: assert property (card_side_clk_en |-> internal_clk_en)
		else $error("card clock without oscillator");
	chk_detect_lag: assert property (card_present == $past(card_detect_pin, 3))
		else $error("card detect lag wrong");
	chk_tmo_pulse: assert property (data_timeout |=> !data_timeout)
		else $error("timeout pulse too long");
endmodule // clock_start_ctrl_assertions
bind clock_start_ctrl clock_start_ctrl_assertions i_chk (.clk, .rstn, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
	.card_detect_pin, .card_present, .internal_clk_en, .card_side_clk_en, .data_timeout);

//--- sim/test_host_clock_start_and_data_timeout.sv
// Self-checking bench for the clock start-up and timeout block.
// Assumes short settle, lock and base divider values for run length.
`timescale 1ns/1ps
module test_host_clock_start_and_data_timeout;
	localparam logic [7:0] cc = clk_start_pkg::clock_ctrl_addr;
	localparam logic [7:0] st = clk_start_pkg::irq_status_addr;
	localparam logic [7:0] en = clk_start_pkg::irq_enable_addr;
	localparam logic [7:0] cl = clk_start_pkg::irq_clear_addr;
	localparam logic [7:0] lk = clk_start_pkg::link_ctrl_addr;
	logic        clk;
	logic        rstn;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        card_detect_pin;
	logic        card_present;
	logic        internal_clk_en;
	logic        card_side_clk_en;
	logic        data_timeout;
	logic        irq;
	logic [31:0] q;
	int          num_errors = 0;
	int          n_compared = 0;
	int          n_pulse = 0;
	int          c;
	clock_start_ctrl #(.base_div(1), .settle_cyc(4), .lock_cyc(8)) i_dut (.clk, .rstn,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .card_detect_pin, .card_present, .internal_clk_en,
		.card_side_clk_en, .data_timeout, .irq);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk) if (data_timeout === 1'b1) n_pulse++;
	task print_verdict;
		if (num_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Idle cycle first, so a strobe is never dropped and raised in one step
	task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		avs_byteenable <= be;
		// Wait request seen as sampled at each rising edge
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			num_errors++;
			print_verdict;
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		acc(a, 1'b1, d, be);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		acc(a, 1'b0, 32'h0000_0000, 4'hF);
		chk(q, exp);
	endtask
	task meas(input int lo, input int hi);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (data_timeout !== 1'b1 && c < 20000);
		if (c >= 20000) begin
			num_errors++;
			print_verdict;
		end
		chk(32'(c >= lo && c <= hi), 32'h0000_0001);
	endtask
	initial begin
		rstn = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h0;
		card_detect_pin = 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(cc, 32'h0000_0000);
		wr(8'h40, 32'hFFFF_FFFF, 4'hF);
		rd(8'h40, 32'h0000_0000);
		wr(cc, 32'h0000_0001, 4'h1);
		repeat (20) @(posedge clk);
		rd(cc, 32'h0000_0003);
		chk(internal_clk_en, 1'b1);
		rd(st, 32'h0000_0001);
		chk(irq, 1'b0);
		wr(en, 32'h0000_0001, 4'h1);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		wr(cl, 32'h0000_0001, 4'h1);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		rd(st, 32'h0000_0000);
		wr(cc, 32'h0000_0009, 4'h1);
		rd(cc, 32'h0000_0009);
		repeat (20) @(posedge clk);
		rd(cc, 32'h0000_000B);
		// Synthesizer alone must not lock without the oscillator
		wr(cc, 32'h0000_0008, 4'h1);
		repeat (30) @(posedge clk);
		rd(cc, 32'h0000_0008);
		chk(internal_clk_en, 1'b0);
		// Gate goes on only once settled reads back set
		wr(cc, 32'h0000_0001, 4'h1);
		repeat (20) @(posedge clk);
		rd(cc, 32'h0000_0003);
		wr(cc, 32'h0000_0005, 4'h1);
		repeat (20) @(posedge clk);
		chk(card_side_clk_en, 1'b1);
		wr(cc, 32'h0000_0001, 4'h1);
		repeat (2) @(posedge clk);
		chk(card_side_clk_en, 1'b0);
		wr(cc, 32'h0000_0000, 4'h1);
		repeat (2) @(posedge clk);
		rd(st, 32'h0000_0001);
		wr(cl, 32'h0000_0001, 4'h1);
		rd(st, 32'h0000_0000);
		rd(cc, 32'h0000_0000);
		card_detect_pin <= 1'b1;
		repeat (5) @(posedge clk);
		chk(card_present, 1'b1);
		rd(lk, 32'h0000_0001);
		card_detect_pin <= 1'b0;
		wr(cc, 32'h0000_0001, 4'h1);
		wr(en, 32'h0000_0001, 4'h1);
		wr(cc, 32'h00FF_0000, 4'h4);
		repeat (20) @(posedge clk);
		rd(cc, 32'h000F_0003);
		wr(cl, 32'h0000_0003, 4'h1);
		wr(lk, 32'h0000_0001, 4'h1);
		repeat (9000) @(posedge clk);
		chk(n_pulse, 32'h0000_0000);
		wr(cc, 32'h0000_0000, 4'h4);
		wr(lk, 32'h0000_0001, 4'h1);
		repeat (4000) @(posedge clk);
		wr(lk, 32'h0000_0001, 4'h1);
		meas(8190, 8196);
		rd(st, 32'h0000_0002);
		wr(cc, 32'h0001_0000, 4'h4);
		wr(lk, 32'h0000_0001, 4'h1);
		meas(16382, 16388);
		// Shortest code, so a missed stop would expire inside the wait
		wr(cc, 32'h0000_0000, 4'h4);
		wr(lk, 32'h0000_0001, 4'h1);
		repeat (100) @(posedge clk);
		wr(lk, 32'h0000_0002, 4'h1);
		c = n_pulse;
		repeat (9000) @(posedge clk);
		chk(n_pulse, c);
		print_verdict;
	end
endmodule // test_host_clock_start_and_data_timeout
